//--- vts_cpu_model.sv
// CPU core stand-in that reports completed instructions.
module vts_cpu_model (
  input wire logic clk_in,
  input wire logic [2:0] gap_in,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  initial done_out = 1'b0;
  // A long gap models a slow instruction and keeps the hold open longer.
  always @(posedge clk_in) begin
    cnt <= (cnt >= gap_in) ? 3'h0 : cnt + 3'h1;
    done_out <= cnt == gap_in;
  end
endmodule

//--- vts_pkg.sv
// Package with constants and types for the vector table select unlock block.
package vts_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] VTS_ADDR_MCU_CONTROL = 8'h00;
  localparam logic [7:0] VTS_ADDR_STATUS = 8'h01;
  localparam logic [7:0] VTS_MCU_CONTROL_RST = 8'h00;
  localparam int VTS_SELECT_BIT = 1;
  localparam int VTS_UNLOCK_BIT = 0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int VTS_UNLOCK_CYCLES = 4;
  localparam logic [2:0] VTS_UNLOCK_CNT = 3'(VTS_UNLOCK_CYCLES);

  // ----------------------------------------
  // Addresses (word addresses of program flash)
  // ----------------------------------------
  localparam logic [15:0] VTS_APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] VTS_VECTOR_OFFSET = 16'h0002;
  // Boot section start per boot size fuse code 0..3; code 0 is the 8K byte section.
  localparam logic [15:0] VTS_BOOT_BASE_0 = 16'hf000;
  localparam logic [15:0] VTS_BOOT_BASE_1 = 16'hf800;
  localparam logic [15:0] VTS_BOOT_BASE_2 = 16'hfc00;
  localparam logic [15:0] VTS_BOOT_BASE_3 = 16'hfe00;

  typedef enum logic [1:0] {VTS_IDLE, VTS_OPEN, VTS_HOLD} vts_state_t;

  typedef struct packed {
    logic [7:0] control;
    vts_state_t state;
    logic [2:0] count;
    logic irq_block;
    logic irq_enable;
    logic [7:0] rdata;
    logic [15:0] reset_addr;
    logic [15:0] vector_base;
  } vts_regs_t;

endpackage

//--- vts_unit.sv
// Vector table placement control with timed unlock and interrupt gating.
module vts_unit
  import vts_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Fuses and lock bits, programmed reads as zero
  input wire logic [1:0] boot_size_fuses_in,
  input wire logic boot_reset_fuse_in,
  input wire logic app_section_lock_bit_in,
  input wire logic boot_section_lock_bit_in,
  // Core status
  input wire logic executing_boot_in,
  input wire logic instr_done_in,
  // Outputs to the core
  output logic irq_enable_out,
  output logic vector_table_select_out,
  output logic [15:0] reset_addr_out,
  output logic [15:0] vector_base_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // State update
  // ----------------------------------------
  vts_regs_t r;
  vts_regs_t next_r;
  logic [15:0] boot_base;
  logic wr_ctl;
  logic sel_bit;
  logic unl_bit;
  logic select;
  logic lock_mask;

  always_comb begin
    // Fuse code picks the boot section start.
    case (boot_size_fuses_in)
      2'b00: boot_base = VTS_BOOT_BASE_0;
      2'b01: boot_base = VTS_BOOT_BASE_1;
      2'b10: boot_base = VTS_BOOT_BASE_2;
      default: boot_base = VTS_BOOT_BASE_3;
    endcase
  end

  assign wr_ctl = wr_in && (addr_in == VTS_ADDR_MCU_CONTROL);
  assign sel_bit = wdata_in[VTS_SELECT_BIT];
  assign unl_bit = wdata_in[VTS_UNLOCK_BIT];
  assign select = r.control[VTS_SELECT_BIT];

  always_comb begin
    next_r = r;
    lock_mask = 1'b0;
    case (r.state)
      VTS_IDLE: begin
        if (wr_ctl) begin
          // Select bit is kept; other control bits store freely.
          next_r.control = {wdata_in[7:2], select, 1'b0};
          if (unl_bit) begin
            next_r.control[VTS_UNLOCK_BIT] = 1'b1;
            next_r.state = VTS_OPEN;
            next_r.count = VTS_UNLOCK_CNT - 3'd1;
          end
        end
      end
      VTS_OPEN: begin
        if (wr_ctl && !unl_bit) begin
          // Select write inside the window takes effect and closes it.
          next_r.control = {wdata_in[7:2], sel_bit, 1'b0};
          next_r.state = VTS_HOLD;
        end else if (r.count == 3'd0) begin
          next_r.control[VTS_UNLOCK_BIT] = 1'b0;
          next_r.state = VTS_IDLE;
        end else begin
          if (wr_ctl) begin
            next_r.control[7:2] = wdata_in[7:2];
          end
          next_r.count = r.count - 3'd1;
        end
      end
      VTS_HOLD: begin
        // Stay blocked until the instruction after the select write ends.
        if (instr_done_in) begin
          next_r.state = VTS_IDLE;
        end
      end
      default: begin
        next_r.state = VTS_IDLE;
      end
    endcase

    next_r.irq_block = (next_r.state != VTS_IDLE);

    // Boot lock gating uses the placement in force now.
    if (select && app_section_lock_bit_in == 1'b0 && !executing_boot_in) begin
      lock_mask = 1'b1;
    end
    if (!select && boot_section_lock_bit_in == 1'b0 && executing_boot_in) begin
      lock_mask = 1'b1;
    end
    // The core's global flag is not touched here; this gate sits after it.
    next_r.irq_enable = !next_r.irq_block && !lock_mask;

    if (rd_in) begin
      case (addr_in)
        VTS_ADDR_MCU_CONTROL: next_r.rdata = r.control;
        VTS_ADDR_STATUS: next_r.rdata = {6'h00, r.irq_block, r.irq_enable};
        default: next_r.rdata = 8'h00;
      endcase
    end else begin
      next_r.rdata = 8'h00;
    end

    // Vector base and reset address from fuses and placement.
    if (next_r.control[VTS_SELECT_BIT]) begin
      next_r.vector_base = boot_base + VTS_VECTOR_OFFSET;
    end else begin
      next_r.vector_base = VTS_APP_RESET_ADDR + VTS_VECTOR_OFFSET;
    end
    next_r.reset_addr = (boot_reset_fuse_in == 1'b0) ? boot_base : VTS_APP_RESET_ADDR;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r.control <= VTS_MCU_CONTROL_RST;
      r.state <= VTS_IDLE;
      r.count <= 3'd0;
      r.irq_block <= 1'b0;
      r.irq_enable <= 1'b0;
      r.rdata <= 8'h00;
      r.reset_addr <= VTS_APP_RESET_ADDR;
      r.vector_base <= VTS_VECTOR_OFFSET;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_out = r.rdata;
  assign irq_enable_out = r.irq_enable;
  assign vector_table_select_out = r.control[VTS_SELECT_BIT];
  assign reset_addr_out = r.reset_addr;
  assign vector_base_out = r.vector_base;

endmodule

//--- vts_unit_checker.sv
// Port assertions for the vector table select unit.
module vts_unit_checker (
  input wire logic clk_in, nrst_in, wr_in, instr_done_in, executing_boot_in, boot_reset_fuse_in,
  input wire logic app_section_lock_bit_in, boot_section_lock_bit_in, irq_enable_out, vector_table_select_out,
  input wire logic [7:0] addr_in, wdata_in,
  input wire logic [1:0] boot_size_fuses_in,
  input wire logic [15:0] reset_addr_out, vector_base_out
);
  logic [1:0] up;
  logic [15:0] base;
  logic w0;
  logic sel;
  assign w0 = wr_in && addr_in == 8'h00;
  assign sel = vector_table_select_out;
  // The internal reset lags two edges, so static checks wait for it.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    base <= ~(16'h0fff >> boot_size_fuses_in);
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_RESET_ADDR: assert property (up == 2'h3 |->
    reset_addr_out == ($past(boot_reset_fuse_in) ? 16'h0000 : base)) else $error("reset address");
  AST_VEC_BASE: assert property (up == 2'h3 |->
    vector_base_out == (sel ? base : 16'h0000) + 16'h0002) else $error("vector base");
  AST_BLOCK: assert property (w0 && wdata_in == 8'h01 && irq_enable_out |=> !irq_enable_out [*4])
    else $error("irq not blocked");
  AST_TIMEOUT: assert property (w0 && wdata_in == 8'h01 && irq_enable_out ##1 !wr_in [*4] |=>
    irq_enable_out || !app_section_lock_bit_in || !boot_section_lock_bit_in) else $error("irq not released");
  AST_NO_UNLOCK: assert property (w0 && !wdata_in[0] && irq_enable_out |=> $stable(sel))
    else $error("select changed");
  AST_SELECT: assert property (w0 && wdata_in == 8'h01 && irq_enable_out ##2 w0 && wdata_in == 8'h02 |=> sel)
    else $error("select not set");
  AST_HOLD: assert property ($changed(sel) && !instr_done_in |=> !irq_enable_out) else $error("hold");
  AST_LOCK: assert property (up == 2'h3 && (sel && !app_section_lock_bit_in && !executing_boot_in
    || !sel && !boot_section_lock_bit_in && executing_boot_in) |=> !irq_enable_out) else $error("lock mask");
endmodule
bind vts_unit vts_unit_checker vts_unit_checker_inst (.*);

//--- vts_unit_tb.sv
// Self-checking testbench for the vector table select unit.
module vts_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, brf = 1'b1, al = 1'b1, bl = 1'b1, ex = 1'b0;
  logic done, irq, sel;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdo, q;
  logic [1:0] fz = 2'h0;
  logic [2:0] gap = 3'h7;
  logic [15:0] ra, vb;
  int errors = 0, tests_run = 0;
  always #20 clk_in = ~clk_in;
  vts_cpu_model vts_cpu_model_inst (.clk_in(clk_in), .gap_in(gap), .done_out(done));
  vts_unit vts_unit_inst (.clk_in(clk_in), .nrst_in(nrst), .ce_in(1'b1), .addr_in(addr), .wdata_in(wd),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdo), .boot_size_fuses_in(fz), .boot_reset_fuse_in(brf),
    .app_section_lock_bit_in(al), .boot_section_lock_bit_in(bl), .executing_boot_in(ex), .instr_done_in(done),
    .irq_enable_out(irq), .vector_table_select_out(sel), .reset_addr_out(ra), .vector_base_out(vb));
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input logic [7:0] a, d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rt(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 q = rdo;
  endtask
  task automatic end_of_test();
    $display("%0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(24675));
    repeat (5) @(posedge clk_in);
    nrst <= 1'b1;
    rt(8'h00);
    rt(8'h00);
    chk("control", q, 8'h00);
    for (int f = 7; f >= 0; f--) begin
      fz <= f[1:0];
      brf <= f[2];
      repeat (3) @(posedge clk_in);
      #1 chk("reset addr", ra, f[2] ? 16'h0000 : ~(16'h0fff >> f[1:0]));
    end
    $display("test fuses done");
    wt(8'h00, 8'h01);
    chk("blocked", irq, 1'b0);
    wt(8'h00, 8'h02);
    chk("select", {sel, irq, ra, vb}, 35'h2f000f002);
    repeat (12) @(posedge clk_in);
    #1 chk("released", irq, 1'b1);
    wt(8'h00, 8'h00);
    wt(8'h00, 8'h01);
    repeat (5) @(posedge clk_in);
    wt(8'h00, 8'h00);
    chk("late", {sel, irq}, 2'h3);
    al <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk("app mask", irq, 1'b0);
    $display("test unlock done");
    al <= 1'b1;
    gap <= 3'h1;
    wt(8'h00, 8'h01);
    wt(8'h00, 8'h00);
    chk("clear", {sel, vb}, 17'h00002);
    bl <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      ex <= 1'($urandom);
      wt(8'h02 + 8'($urandom_range(253)), 8'($urandom));
      rt(8'h02 + 8'($urandom_range(253)));
      chk("lock", {sel, irq, q}, {2'b0, ~ex, 8'h00});
    end
    $display("test random done");
    end_of_test();
  end
endmodule
